// ### include/trig_qual_pkg.sv
package trig_qual_pkg;
   // apb register byte offsets
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_min_width = 8'h04;
   localparam logic [7:0] off_frame_count = 8'h08;
   localparam logic [7:0] off_start_delay = 8'h0c;
   localparam logic [7:0] off_status = 8'h10;
   localparam logic [7:0] off_reserve = 8'h14;
   // ctrl field positions
   localparam int ctrl_enable_bit = 0;
   localparam int ctrl_scan_bit = 1;
   localparam int ctrl_mode_lo = 4;
   localparam int ctrl_base_lo = 8;
   localparam int ctrl_sel_lo = 12;
   // status field positions
   localparam int stat_busy_bit = 0;
   localparam int stat_delay_bit = 1;
   localparam int stat_level_bit = 2;
   localparam int stat_bad_count_bit = 3;
   localparam int stat_accepted_lo = 16;
   // reserve register: inputs in low half, outputs in high half
   localparam int reserve_out_lo = 16;
   localparam logic [3:0] reserve_in_reset = 4'h3;
   localparam logic [3:0] reserve_out_reset = 4'h3;
   // frame count limits
   localparam logic [17:0] frame_count_min = 18'h00001;
   localparam logic [17:0] frame_count_max = 18'h3fffe;
   localparam logic [17:0] frame_count_reset = 18'h00001;
   // timing
   localparam int clock_mhz = 125;
   localparam int time_unit_us = 1;
   localparam int cycles_per_us = time_unit_us * clock_mhz;
   localparam int ns_per_clock = 8;
   localparam logic [31:0] zero_word = 32'h00000000;

   typedef enum logic [2:0] {
      mode_level_low = 3'b000,
      mode_level_high = 3'b001,
      mode_edge_rise = 3'b010,
      mode_edge_fall = 3'b011,
      mode_dual_rise = 3'b100,
      mode_dual_fall = 3'b101
   } detect_mode_t;

   typedef enum logic [1:0] {
      base_line = 2'b00,
      base_ns = 2'b01,
      base_line_or_shaft = 2'b10,
      base_shaft = 2'b11
   } delay_base_t;

   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_delay = 2'b01,
      seq_frames = 2'b10,
      seq_level = 2'b11
   } seq_state_t;
endpackage

// ### verilog/trig_input_sync.sv
`timescale 1ns/1ps
module trig_input_sync #(
   parameter int width = 4
) (
   // clocking
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_en,
   // pins and result
   input wire logic [width-1:0] pin_in,
   output logic [width-1:0] pin_level
);
   logic [width-1:0] stage1;
   logic [width-1:0] stage2;
   logic [width-1:0] stage3;

   // third stage only filters: change counts once stages two and three agree
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         pin_level <= '0;
      end else if (clock_en) begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < width; i++) begin
            if (stage2[i] == stage3[i]) begin
               pin_level[i] <= stage3[i];
            end
         end
      end
   end
endmodule

// ### verilog/external_frame_trigger_qualifier.sv
// What this block does
// - enable gates frame requests to trigger, areascan
// - level mode captures while input active
// - one frame sequence per qualifying edge
// - linescan adds dual-input rising/falling modes
// - measure pulse width, drop short pulses
// - zero minimum width accepts every pulse
// - frames per trigger, 1 through 262142
// - infinite or out-of-range count refused
// - programmable start delay after accepted trigger
// - delay counts line, ns, or encoder events
// - selector picks which input feeds trigger
// - only reserved inputs reach trigger logic, except the dual-mode second input, which is not checked
// - inputs and outputs 1, 2 reserved at reset
`timescale 1ns/1ps
module external_frame_trigger_qualifier
   import trig_qual_pkg::*;
#(
   parameter int n_inputs = 4,
   parameter int delay_width = 32,
   parameter int width_us_width = 16
) (
   // clocking
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger inputs and time base events
   input wire logic [n_inputs-1:0] gen_input,
   input wire logic line_tick,
   input wire logic line_trig_tick,
   input wire logic shaft_tick,
   // acquisition engine
   output logic frame_request,
   output logic capture_active,
   input wire logic frame_done,
   output logic [3:0] strobe_reserved
);
   logic [31:0] ctrl;
   logic [width_us_width-1:0] min_pulse_width;
   logic [17:0] frames_per_trigger;
   logic [delay_width-1:0] trig_start_delay;
   logic [3:0] reserve_in;
   logic bad_count;
   logic [15:0] accepted_count;
   logic [n_inputs-1:0] pin_level;
   logic trig_now;
   logic dual_prev;
   logic [width_us_width-1:0] us_count;
   logic [7:0] us_prescale;
   logic pulse_ok;
   logic accept;
   seq_state_t seq_state;
   logic [delay_width-1:0] delay_count;
   logic [17:0] frames_left;
   logic wait_done;
   logic [delay_width-1:0] ns_acc;

   logic ext_trig_enable;
   logic camera_scan_type;
   detect_mode_t trig_detect_mode;
   delay_base_t delay_base;
   logic [1:0] trig_input_select;
   assign ext_trig_enable = ctrl[ctrl_enable_bit];
   assign camera_scan_type = ctrl[ctrl_scan_bit];
   assign trig_detect_mode = detect_mode_t'(ctrl[ctrl_mode_lo +: 3]);
   assign delay_base = delay_base_t'(ctrl[ctrl_base_lo +: 2]);
   assign trig_input_select = ctrl[ctrl_sel_lo +: 2];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic wr_en;
   logic rd_en;
   logic [31:0] cur_word;
   logic [31:0] wr_word;
   assign wr_en = psel && penable && pwrite && clock_en;
   assign rd_en = psel && !penable && !pwrite && clock_en;
   // byte lanes merge into the old word before any range check sees it
   assign wr_word = merge(cur_word, pwdata, pstrb);

   trig_input_sync #(.width(n_inputs)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .clock_en(clock_en),
      .pin_in(gen_input),
      .pin_level(pin_level)
   );

   always_comb begin
      trig_now = 1'b0;
      if (reserve_in[trig_input_select] && int'(trig_input_select) < n_inputs) begin
         trig_now = pin_level[trig_input_select];
      end
   end

   // addressed register, shared by reads and byte-lane merges
   always_comb begin
      unique case (paddr)
         off_ctrl: cur_word = ctrl;
         off_min_width: cur_word = 32'(min_pulse_width);
         off_frame_count: cur_word = 32'(frames_per_trigger);
         off_start_delay: cur_word = 32'(trig_start_delay);
         off_status: cur_word = {accepted_count, 12'h000, bad_count, trig_now,
                                 seq_state == seq_delay, seq_state != seq_idle};
         off_reserve: cur_word = {12'h000, strobe_reserved, 12'h000, reserve_in};
         default: cur_word = zero_word;
      endcase
   end

   // registers; one-wait-state slaves would need no pready flop, kept zero-wait
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl <= zero_word;
         min_pulse_width <= '0;
         frames_per_trigger <= frame_count_reset;
         trig_start_delay <= '0;
         reserve_in <= reserve_in_reset;
         strobe_reserved <= reserve_out_reset;
         bad_count <= 1'b0;
      end else if (wr_en) begin
         unique case (paddr)
            off_ctrl: ctrl <= wr_word;
            off_min_width: min_pulse_width <= wr_word[width_us_width-1:0];
            off_frame_count: begin
               if (wr_word[17:0] >= frame_count_min && wr_word[17:0] <= frame_count_max
                   && wr_word[31:18] == '0) begin
                  frames_per_trigger <= wr_word[17:0];
                  bad_count <= 1'b0;
               end else begin
                  bad_count <= 1'b1;
               end
            end
            off_start_delay: trig_start_delay <= wr_word[delay_width-1:0];
            off_reserve: begin
               reserve_in <= wr_word[3:0];
               strobe_reserved <= wr_word[reserve_out_lo +: 4];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prdata <= zero_word;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clock_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(paddr inside {off_ctrl, off_min_width,
                    off_frame_count, off_start_delay, off_status, off_reserve});
         if (rd_en) begin
            prdata <= cur_word;
         end
      end
   end

   // pulse width in microseconds, counted while input active
   logic active_lvl;
   logic falling_mode;
   assign falling_mode = trig_detect_mode inside {mode_level_low, mode_edge_fall, mode_dual_fall};
   assign active_lvl = falling_mode ? !trig_now : trig_now;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         us_count <= '0;
         us_prescale <= '0;
         dual_prev <= 1'b0;
      end else if (clock_en) begin
         if (!active_lvl) begin
            us_count <= '0;
            us_prescale <= '0;
         end else if (int'(us_prescale) == cycles_per_us - 1) begin
            us_prescale <= '0;
            if (us_count != '1) begin
               us_count <= us_count + 1'b1;
            end
         end else begin
            us_prescale <= us_prescale + 1'b1;
         end
         dual_prev <= pin_level[(int'(trig_input_select) + 1) % n_inputs];
      end
   end

   assign pulse_ok = (min_pulse_width == '0) || (us_count >= min_pulse_width);

   // edge qualifies once width reached (leading edge while pulse held)
   // dual-input: second input of pair must also be active
   logic qual_event;
   logic qual_prev;
   logic dual_ok;
   assign dual_ok = (trig_detect_mode inside {mode_dual_rise, mode_dual_fall}) ?
                    camera_scan_type && (falling_mode ? !dual_prev : dual_prev) : 1'b1;
   assign qual_event = active_lvl && pulse_ok && dual_ok;
   assign accept = ext_trig_enable && qual_event && !qual_prev && seq_state == seq_idle;

   always_comb begin
      wait_done = 1'b0;
      unique case (delay_base)
         base_line: wait_done = line_tick;
         base_ns: wait_done = 1'b1;
         base_line_or_shaft: wait_done = line_trig_tick || shaft_tick;
         base_shaft: wait_done = shaft_tick;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         seq_state <= seq_idle;
         delay_count <= '0;
         ns_acc <= '0;
         frames_left <= '0;
         frame_request <= 1'b0;
         capture_active <= 1'b0;
         qual_prev <= 1'b0;
         accepted_count <= '0;
      end else if (clock_en) begin
         qual_prev <= qual_event;
         frame_request <= 1'b0;
         unique case (seq_state)
            seq_idle: begin
               capture_active <= 1'b0;
               if (accept) begin
                  accepted_count <= accepted_count + 1'b1;
                  delay_count <= '0;
                  ns_acc <= '0;
                  frames_left <= frames_per_trigger;
                  seq_state <= seq_delay;
               end
            end
            seq_delay: begin
               if (delay_count >= trig_start_delay) begin
                  capture_active <= 1'b1;
                  frame_request <= 1'b1;
                  if (trig_detect_mode inside {mode_level_low, mode_level_high}) begin
                     seq_state <= seq_level;
                  end else begin
                     seq_state <= seq_frames;
                  end
               end else if (wait_done) begin
                  if (delay_base == base_ns) begin
                     delay_count <= ns_acc + delay_width'(ns_per_clock);
                     ns_acc <= ns_acc + delay_width'(ns_per_clock);
                  end else begin
                     delay_count <= delay_count + 1'b1;
                  end
               end
            end
            seq_frames: begin
               if (frame_done) begin
                  if (frames_left <= frame_count_min) begin
                     capture_active <= 1'b0;
                     seq_state <= seq_idle;
                  end else begin
                     frames_left <= frames_left - 1'b1;
                     frame_request <= 1'b1;
                  end
               end
            end
            seq_level: begin
               if (frame_done) begin
                  if (active_lvl && ext_trig_enable) begin
                     frame_request <= 1'b1;
                  end else begin
                     capture_active <= 1'b0;
                     seq_state <= seq_idle;
                  end
               end
            end
         endcase
      end
   end
endmodule

// ### bench/trig_qual_sva.sv
`timescale 1ns/1ps
module trig_qual_sva (
   // clocking
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // acquisition engine
   input wire logic frame_request,
   input wire logic capture_active,
   input wire logic frame_done,
   input wire logic [3:0] strobe_reserved
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic pending;
   // a frame is outstanding from its request until the engine reports done
   always_ff @(posedge clock) begin
      if (sys_rst) pending <= 1'b0;
      else if (frame_done) pending <= 1'b0;
      else if (frame_request) pending <= 1'b1;
   end
   property p_ready;
      psel && !penable && clock_en |=> pready;
   endproperty
   property p_ready_q;
      pready |-> psel && penable;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_pulse;
      frame_request |=> !frame_request;
   endproperty
   property p_act;
      frame_request |-> capture_active;
   endproperty
   property p_pend;
      frame_request |-> !pending;
   endproperty
   property p_rst;
      disable iff (1'b0) sys_rst && clock_en |=>
         strobe_reserved == 4'h3 && !capture_active && !frame_request;
   endproperty
   property p_freeze;
      !clock_en |=> $stable(capture_active) && $stable(frame_request);
   endproperty
   property p_end;
      $fell(capture_active) && !$past(sys_rst) |-> $past(frame_done);
   endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   a_ready_q: assert property (p_ready_q) else $error("ready outside access");
   a_err: assert property (p_err) else $error("error without ready");
   a_pulse: assert property (p_pulse) else $error("request too long");
   a_act: assert property (p_act) else $error("request while not active");
   a_pend: assert property (p_pend) else $error("request while busy");
   a_rst: assert property (p_rst) else $error("bad reset values");
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   a_end: assert property (p_end) else $error("sequence cut short");
   c_req: cover property (frame_request ##[1:200] frame_request);
   c_err: cover property (pslverr);
   c_end: cover property ($fell(capture_active));
endmodule
bind external_frame_trigger_qualifier trig_qual_sva i_sva (.clock(clock),
   .sys_rst(sys_rst), .clock_en(clock_en), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .frame_request(frame_request),
   .capture_active(capture_active), .frame_done(frame_done),
   .strobe_reserved(strobe_reserved));

// ### bench/acq_engine_model.sv
`timescale 1ns/1ps
module acq_engine_model (
   // clocking
   input wire logic clock,
   input wire logic sys_rst,
   // request and answer
   input wire logic frame_request,
   input wire logic [7:0] latency,
   output logic frame_done
);
   int cnt;
   // one frame at a time; a long latency keeps the block busy
   always @(posedge clock) begin
      if (sys_rst) begin
         cnt <= 0;
         frame_done <= 1'b0;
      end else if (frame_request === 1'b1) begin
         cnt <= latency;
         frame_done <= 1'b0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
         frame_done <= 1'b0;
      end else begin
         cnt <= 0;
         frame_done <= (cnt == 1);
      end
   end
endmodule

// ### bench/external_frame_trigger_qualifier_tb.sv
`timescale 1ns/1ps
module external_frame_trigger_qualifier_tb;
   import trig_qual_pkg::*;
   typedef struct {
      logic [15:0] ctrl;
      logic [3:0] res;
      int wid, frm, dly, pul, hold, lat, exp;
   } row_t;
   logic clock = 1'b0, sys_rst = 1'b1, clock_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e, act;
   logic [7:0] paddr = 8'h00, latency = 8'h05;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic [3:0] pstrb = 4'hf, gen_input = 4'h0, strobe_reserved, mask;
   logic line_tick = 1'b0, line_trig_tick = 1'b0, shaft_tick = 1'b0;
   logic frame_request, capture_active, frame_done;
   int errors = 0, total_checks = 0, req_cnt = 0, tick_n = 0, k, req_base;
   logic [31:0] bad [3] = '{32'h0, 32'h3ffff, 32'hffffffff};
   row_t rows [16];
   external_frame_trigger_qualifier i_dut (.clock(clock), .sys_rst(sys_rst),
      .clock_en(clock_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gen_input(gen_input),
      .line_tick(line_tick), .line_trig_tick(line_trig_tick),
      .shaft_tick(shaft_tick), .frame_request(frame_request),
      .capture_active(capture_active), .frame_done(frame_done),
      .strobe_reserved(strobe_reserved));
   acq_engine_model i_eng (.clock(clock), .sys_rst(sys_rst),
      .frame_request(frame_request), .latency(latency), .frame_done(frame_done));
   always #4 clock = ~clock;
   // time base events at unrelated rates
   always @(posedge clock) begin
      tick_n <= tick_n + 1;
      line_tick <= (tick_n % 4 == 0);
      line_trig_tick <= (tick_n % 5 == 0);
      shaft_tick <= (tick_n % 6 == 0);
      if (frame_request === 1'b1) req_cnt <= req_cnt + 1;
   end
   task summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task hang;
      errors++;
      summarize;
   endtask
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (n == 50) hang;
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // disable first so the new idle level never looks like a trigger
   task setup(input row_t r);
      act = (r.ctrl[6:4] inside {3'd0, 3'd3, 3'd5}) ? 1'b0 : 1'b1;
      mask = (r.ctrl[6] ? 4'h3 : 4'h1) << r.ctrl[13:12];
      latency <= 8'(r.lat);
      apb(1'b1, off_ctrl, zero_word);
      gen_input <= {4{~act}};
      apb(1'b1, off_reserve, {12'h000, 4'h3, 12'h000, r.res});
      apb(1'b1, off_min_width, 32'(r.wid));
      apb(1'b1, off_frame_count, 32'(r.frm));
      apb(1'b1, off_start_delay, 32'(r.dly));
      apb(1'b1, off_ctrl, {16'h0000, r.ctrl});
      @(posedge clock);
      clock_en <= 1'b0;
      repeat (3) @(posedge clock);
      clock_en <= 1'b1;
      repeat (10) @(posedge clock);
      req_base = req_cnt;
   endtask
   initial begin
      rows = '{'{16'h0021, 4'h3, 0, 3, 0, 1, 20, 5, 3},
         '{16'h0031, 4'h3, 0, 1, 0, 1, 20, 5, 1}, '{16'h0011, 4'h3, 0, 1, 0, 1, 300, 8, -1},
         '{16'h0001, 4'h3, 0, 1, 0, 1, 300, 8, -1}, '{16'h0043, 4'h3, 0, 2, 0, 1, 20, 5, 2},
         '{16'h0053, 4'h3, 0, 2, 0, 1, 20, 5, 2}, '{16'h0021, 4'h3, 1, 1, 0, 1, 60, 5, 0},
         '{16'h0021, 4'h3, 1, 1, 0, 1, 200, 5, 1}, '{16'h0121, 4'h3, 0, 2, 80, 1, 20, 5, 2},
         '{16'h0021, 4'h3, 0, 1, 3, 1, 20, 5, 1}, '{16'h0221, 4'h3, 0, 1, 3, 1, 20, 5, 1},
         '{16'h0321, 4'h3, 0, 1, 3, 1, 20, 5, 1}, '{16'h0020, 4'h3, 0, 1, 0, 1, 20, 5, 0},
         '{16'h3021, 4'h3, 0, 1, 0, 1, 20, 5, 0}, '{16'h2021, 4'h7, 0, 1, 0, 1, 20, 5, 1},
         '{16'h0021, 4'h3, 0, 2, 0, 2, 20, 100, 2}};
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      chk_word({28'h0, strobe_reserved}, 32'h3);
      apb(1'b0, off_reserve, zero_word);
      chk_word(d, 32'h00030003);
      apb(1'b0, off_frame_count, zero_word);
      chk_word(d, 32'h1);
      foreach (rows[i]) begin
         setup(rows[i]);
         repeat (rows[i].pul) begin
            gen_input <= act ? mask : ~mask;
            repeat (rows[i].hold) @(posedge clock);
            gen_input <= {4{~act}};
            repeat (20) @(posedge clock);
         end
         for (k = 0; k < 3000 && capture_active !== 1'b0; k++) @(posedge clock);
         if (k == 3000) hang;
         if (rows[i].exp < 0) chk_cnt(int'(req_cnt - req_base > 2), 1);
         else chk_cnt(req_cnt - req_base, rows[i].exp);
      end
      apb(1'b1, off_frame_count, 32'h5);
      foreach (bad[j]) begin
         apb(1'b1, off_frame_count, bad[j]);
         apb(1'b0, off_status, zero_word);
         chk_word(d & 32'h8, 32'h8);
         apb(1'b0, off_frame_count, zero_word);
         chk_word(d, 32'h5);
      end
      apb(1'b1, off_frame_count, 32'h3fffe);
      apb(1'b0, off_frame_count, zero_word);
      chk_word(d, 32'h3fffe);
      apb(1'b0, off_status, zero_word);
      chk_word(d & 32'h8, 32'h0);
      apb(1'b0, 8'h18, zero_word);
      chk_word({31'h0, e}, 32'h1);
      chk_word(d, zero_word);
      // only the low byte lane may change
      apb(1'b1, off_min_width, 32'h00001234);
      pstrb <= 4'h1;
      apb(1'b1, off_min_width, 32'hffffff56);
      pstrb <= 4'hf;
      apb(1'b0, off_min_width, zero_word);
      chk_word(d, 32'h00001256);
      setup(row_t'{16'h0121, 4'h3, 0, 1, 800, 1, 0, 5, 1});
      gen_input <= 4'h1;
      for (k = 0; k < 300 && frame_request !== 1'b1; k++) @(posedge clock);
      // 800 ns is 100 clocks, plus sync and accept
      chk_cnt(int'(k >= 100 && k <= 115), 1);
      summarize;
   end
endmodule
